/* include/dsp_cfg.svh */
`ifndef DSP_CFG_SVH
`define DSP_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DSP_OFS_CTRL  8'h00
`define DSP_OFS_CNT   8'h04
`define DSP_OFS_CMPA  8'h08
`define DSP_OFS_CMPB  8'h0C
`define DSP_OFS_CAP   8'h10
`define DSP_OFS_FLAGS 8'h14
`define DSP_OFS_STAT  8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DSP_F_WGM  0
`define DSP_F_COMA 4
`define DSP_F_COMB 6
`define DSP_F_CS   8
`define DSP_F_DIRA 11
`define DSP_F_DIRB 12
`define DSP_F_OVF  0
`define DSP_F_OCFA 1
`define DSP_F_OCFB 2
`define DSP_F_CAPF 3
`define DSP_F_UP   0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DSP_RST_CTRL 13'h0000
`define DSP_RST_CNT  16'h0000
`define DSP_RST_CAP  16'h0000
`define DSP_RST_CMP  16'h0000

// ----------------------------------------
// Mode codes and fixed tops
// ----------------------------------------
`define DSP_WGM_PC8     4'h1
`define DSP_WGM_PC9     4'h2
`define DSP_WGM_PC10    4'h3
`define DSP_WGM_PC_CAP  4'hA
`define DSP_WGM_PC_CMPA 4'hB
`define DSP_WGM_PF_CAP  4'h8
`define DSP_WGM_PF_CMPA 4'h9
`define DSP_TOP_8BIT    16'h00FF
`define DSP_TOP_9BIT    16'h01FF
`define DSP_TOP_10BIT   16'h03FF

// ----------------------------------------
// Prescaler masks (divide by N, mask N-1)
// ----------------------------------------
`define DSP_PS_M1    10'h000
`define DSP_PS_M8    10'h007
`define DSP_PS_M64   10'h03F
`define DSP_PS_M256  10'h0FF
`define DSP_PS_M1024 10'h3FF

`endif

/* include/dsp_pkg.sv */
package dsp_pkg;

  typedef enum logic [1:0] {
    DSP_BUS_IDLE = 2'b01,
    DSP_BUS_EXEC = 2'b10
  } dsp_bus_st_t;

  typedef enum logic [1:0] {
    DSP_DIR_UP   = 2'b01,
    DSP_DIR_DOWN = 2'b10
  } dsp_dir_t;

  typedef struct packed {
    logic       dirB;
    logic       dirA;
    logic [2:0] cs;
    logic [1:0] comB;
    logic [1:0] comA;
    logic [3:0] wgm;
  } dsp_ctrl_t;

  typedef struct packed {
    logic       ovf;
    logic [1:0] ocf;
    logic       capf;
  } dsp_flags_t;

  typedef struct packed {
    logic        run;
    logic        load;
    logic        direct;
    logic        upNow;
    logic [15:0] cnt;
    logic [15:0] top;
  } dsp_cmp_ctx_t;

  typedef struct packed {
    logic [15:0] buffer;
    logic [15:0] active;
    logic        level;
  } dsp_chan_state_t;

  typedef struct packed {
    logic [9:0] div;
    logic       tick;
  } dsp_ps_state_t;

  typedef struct packed {
    dsp_bus_st_t bus;
    logic [7:0]  addr;
    logic        wr;
    logic        ready;
    logic        resp;
    logic [31:0] rdata;
    dsp_ctrl_t   ctrl;
    logic [15:0] cnt;
    dsp_dir_t    dir;
    logic [15:0] cap;
    dsp_flags_t  flg;
    logic [1:0]  pinOut;
    logic [1:0]  pinOe;
  } dsp_top_state_t;

endpackage : dsp_pkg

/* rtl/dsp_prescaler.sv */
`timescale 1ns/1ps
`include "dsp_cfg.svh"

module dsp_prescaler
  import dsp_pkg::*;
(
  input  logic       clk,
  input  logic       nrst,
  input  logic [2:0] clkSel,
  output logic       tick
);

  dsp_ps_state_t st_ff;
  dsp_ps_state_t nxt_st;

  function automatic logic [9:0] divMask(input logic [2:0] sel);
    case (sel)
      3'h1:    divMask = `DSP_PS_M1;
      3'h2:    divMask = `DSP_PS_M8;
      3'h3:    divMask = `DSP_PS_M64;
      3'h4:    divMask = `DSP_PS_M256;
      default: divMask = `DSP_PS_M1024;
    endcase
  endfunction : divMask

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.div = st_ff.div + 10'h001;
    nxt_st.tick = (clkSel != 3'h0) && (clkSel <= 3'h5) &&
                  ((st_ff.div & divMask(clkSel)) == divMask(clkSel));
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

endmodule : dsp_prescaler

/* rtl/dsp_cmp_channel.sv */
`timescale 1ns/1ps
`include "dsp_cfg.svh"

module dsp_cmp_channel
  import dsp_pkg::*;
(
  input  logic         clk,
  input  logic         nrst,
  input  dsp_cmp_ctx_t ctx,
  input  logic         wrEn,
  input  logic [15:0]  wrData,
  output logic [15:0]  cmpActive,
  output logic [15:0]  cmpBuffer,
  output logic         match,
  output logic         level
);

  dsp_chan_state_t st_ff;
  dsp_chan_state_t nxt_st;
  logic            matchNow;

  assign matchNow = ctx.run && (ctx.cnt == st_ff.active);

  always_comb begin
    nxt_st = st_ff;
    if (wrEn) begin
      nxt_st.buffer = wrData;
    end
    if (matchNow) begin
      if (st_ff.active == 16'h0000) begin
        nxt_st.level = 1'b0;
      end else if (st_ff.active == ctx.top) begin
        nxt_st.level = 1'b1;
      end else begin
        nxt_st.level = ~ctx.upNow;
      end
    end
    // Old value compared this step, new value from the next one
    if (ctx.load) begin
      nxt_st.active = st_ff.buffer;
    end
    // Unsupported modes never count, so have no update point to wait for
    if (ctx.direct && wrEn) begin
      nxt_st.active = wrData;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '{buffer: `DSP_RST_CMP, active: `DSP_RST_CMP, level: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cmpActive = st_ff.active;
  assign cmpBuffer = st_ff.buffer;
  assign match     = matchNow;
  assign level     = st_ff.level;

endmodule : dsp_cmp_channel

/* rtl/dsp_pwm_timer.sv */
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "dsp_cfg.svh"

// Notes on behaviour
// - Modes 1, 2, 3, 10, 11 count zero up to TOP and back down.
// - Phase correct TOP: 0x00FF, 0x01FF, 0x03FF, capture value, or compare A.
// - Frequency correct TOP: capture value in mode 8, compare A in mode 9.
// - Counter stays at TOP one timer step, then counts down.
// - Non-inverted: clear on up match, set on down match; inverted opposite.
// - Output mode two gives non-inverted, three gives inverted PWM.
// - Pin driven only while its direction bit selects output.
// - Channel match flag set whenever the running counter equals its compare value.
// - Phase correct sets the overflow flag whenever the counter reaches zero.
// - Phase correct loads compares at TOP; TOP source flag set then.
// - Frequency correct loads compares at zero with the overflow flag.
// - Frequency correct sets the TOP source flag when reaching TOP.
// - Fixed TOP masks compare bits above resolution on every write.
// - Phase correct periods run TOP to TOP; new TOP shapes up slope.
// - Non-inverted: compare zero holds output low, compare TOP holds it high; inverted opposite.
// - Timer steps on I/O clock divided by 1, 8, 64, 256 or 1024.
// - Compare A writes land in a buffer, copied at the update point.
// - Capture value has no buffer; writes act as TOP at once.

module dsp_pwm_timer
  import dsp_pkg::*;
(
  input  logic        clk,
  input  logic        nrst,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic        hreadyout,
  output logic        hresp,
  output logic [31:0] hrdata,
  output logic        compareOutputA,
  output logic        compareOutputAOe,
  output logic        compareOutputB,
  output logic        compareOutputBOe
);

  localparam dsp_top_state_t StRst = '{
    bus:    DSP_BUS_IDLE,
    addr:   8'h00,
    wr:     1'b0,
    ready:  1'b1,
    resp:   1'b0,
    rdata:  32'h0000_0000,
    ctrl:   `DSP_RST_CTRL,
    cnt:    `DSP_RST_CNT,
    dir:    DSP_DIR_UP,
    cap:    `DSP_RST_CAP,
    flg:    4'h0,
    pinOut: 2'b00,
    pinOe:  2'b00
  };

  dsp_top_state_t st_ff;
  dsp_top_state_t nxt_st;

  logic         tick;
  logic         isPc;
  logic         isPf;
  logic         run;
  logic         atTop;
  logic         atZero;
  logic [15:0]  topVal;
  logic [15:0]  wrMask;
  logic [15:0]  cmpActA;
  logic [15:0]  cmpActB;
  logic [15:0]  cmpBufA;
  logic [15:0]  cmpBufB;
  logic         matchA;
  logic         matchB;
  logic         levelA;
  logic         levelB;
  logic         busWr;
  logic         wrCmpA;
  logic         wrCmpB;
  logic [31:0]  rdWord;
  dsp_cmp_ctx_t ctx;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  function automatic logic phaseCorrect(input logic [3:0] wgm);
    phaseCorrect = (wgm == `DSP_WGM_PC8) || (wgm == `DSP_WGM_PC9) || (wgm == `DSP_WGM_PC10) ||
                   (wgm == `DSP_WGM_PC_CAP) || (wgm == `DSP_WGM_PC_CMPA);
  endfunction : phaseCorrect

  function automatic logic topFromCap(input logic [3:0] wgm);
    topFromCap = (wgm == `DSP_WGM_PC_CAP) || (wgm == `DSP_WGM_PF_CAP);
  endfunction : topFromCap

  function automatic logic topFromCmpA(input logic [3:0] wgm);
    topFromCmpA = (wgm == `DSP_WGM_PC_CMPA) || (wgm == `DSP_WGM_PF_CMPA);
  endfunction : topFromCmpA

  function automatic logic [15:0] fixedTop(input logic [3:0] wgm);
    case (wgm)
      `DSP_WGM_PC8:  fixedTop = `DSP_TOP_8BIT;
      `DSP_WGM_PC9:  fixedTop = `DSP_TOP_9BIT;
      `DSP_WGM_PC10: fixedTop = `DSP_TOP_10BIT;
      default:       fixedTop = 16'hFFFF;
    endcase
  endfunction : fixedTop

  assign isPc = phaseCorrect(st_ff.ctrl.wgm);
  assign isPf = (st_ff.ctrl.wgm == `DSP_WGM_PF_CAP) || (st_ff.ctrl.wgm == `DSP_WGM_PF_CMPA);

  assign topVal = topFromCap(st_ff.ctrl.wgm)  ? st_ff.cap :
                  topFromCmpA(st_ff.ctrl.wgm) ? cmpActA :
                  fixedTop(st_ff.ctrl.wgm);

  assign wrMask = fixedTop(st_ff.ctrl.wgm);

  assign run    = tick && (isPc || isPf);
  assign atTop  = (st_ff.cnt == topVal);
  assign atZero = (st_ff.cnt == 16'h0000);

  // ----------------------------------------
  // Timer clock and compare channels
  // ----------------------------------------
  dsp_prescaler u_prescaler (
    .clk    (clk),
    .nrst   (nrst),
    .clkSel (st_ff.ctrl.cs),
    .tick   (tick)
  );

  assign ctx.run    = run;
  assign ctx.load   = run && (isPc ? atTop : atZero);
  assign ctx.direct = !(isPc || isPf);
  assign ctx.upNow  = (st_ff.dir == DSP_DIR_UP);
  assign ctx.cnt    = st_ff.cnt;
  assign ctx.top    = topVal;

  assign busWr  = (st_ff.bus == DSP_BUS_EXEC) && st_ff.wr;
  assign wrCmpA = busWr && (st_ff.addr == `DSP_OFS_CMPA);
  assign wrCmpB = busWr && (st_ff.addr == `DSP_OFS_CMPB);

  dsp_cmp_channel u_chan_a (
    .clk       (clk),
    .nrst      (nrst),
    .ctx       (ctx),
    .wrEn      (wrCmpA),
    .wrData    (hwdata[15:0] & wrMask),
    .cmpActive (cmpActA),
    .cmpBuffer (cmpBufA),
    .match     (matchA),
    .level     (levelA)
  );

  dsp_cmp_channel u_chan_b (
    .clk       (clk),
    .nrst      (nrst),
    .ctx       (ctx),
    .wrEn      (wrCmpB),
    .wrData    (hwdata[15:0] & wrMask),
    .cmpActive (cmpActB),
    .cmpBuffer (cmpBufB),
    .match     (matchB),
    .level     (levelB)
  );

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------
  always_comb begin
    rdWord = 32'h0000_0000;
    if (st_ff.addr == `DSP_OFS_CTRL) begin
      rdWord[`DSP_F_WGM +: 4]  = st_ff.ctrl.wgm;
      rdWord[`DSP_F_COMA +: 2] = st_ff.ctrl.comA;
      rdWord[`DSP_F_COMB +: 2] = st_ff.ctrl.comB;
      rdWord[`DSP_F_CS +: 3]   = st_ff.ctrl.cs;
      rdWord[`DSP_F_DIRA]      = st_ff.ctrl.dirA;
      rdWord[`DSP_F_DIRB]      = st_ff.ctrl.dirB;
    end else if (st_ff.addr == `DSP_OFS_CNT) begin
      rdWord[15:0] = st_ff.cnt;
    end else if (st_ff.addr == `DSP_OFS_CMPA) begin
      rdWord[15:0] = cmpBufA;
    end else if (st_ff.addr == `DSP_OFS_CMPB) begin
      rdWord[15:0] = cmpBufB;
    end else if (st_ff.addr == `DSP_OFS_CAP) begin
      rdWord[15:0] = st_ff.cap;
    end else if (st_ff.addr == `DSP_OFS_FLAGS) begin
      rdWord[`DSP_F_OVF]  = st_ff.flg.ovf;
      rdWord[`DSP_F_OCFA] = st_ff.flg.ocf[0];
      rdWord[`DSP_F_OCFB] = st_ff.flg.ocf[1];
      rdWord[`DSP_F_CAPF] = st_ff.flg.capf;
    end else if (st_ff.addr == `DSP_OFS_STAT) begin
      rdWord[`DSP_F_UP] = (st_ff.dir == DSP_DIR_UP);
    end
  end

  // ----------------------------------------
  // State update
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // Bus: one wait state, so reads always see settled state
    case (st_ff.bus)
      DSP_BUS_IDLE: begin
        if (hsel && hready && htrans[1]) begin
          nxt_st.bus   = DSP_BUS_EXEC;
          nxt_st.addr  = haddr[7:0];
          nxt_st.wr    = hwrite;
          nxt_st.ready = 1'b0;
        end
      end
      DSP_BUS_EXEC: begin
        nxt_st.bus   = DSP_BUS_IDLE;
        nxt_st.ready = 1'b1;
        if (!st_ff.wr) begin
          nxt_st.rdata = rdWord;
        end
      end
      default: begin
        nxt_st.bus   = DSP_BUS_IDLE;
        nxt_st.ready = 1'b1;
      end
    endcase

    // Dual-slope counter
    if (run) begin
      if (st_ff.dir == DSP_DIR_UP) begin
        if (atTop) begin
          // turn after one step at TOP
          nxt_st.dir = DSP_DIR_DOWN;
          nxt_st.cnt = st_ff.cnt - 16'h0001;
        end else begin
          // Missed TOP wraps through 0xFFFF, as software was warned
          nxt_st.cnt = st_ff.cnt + 16'h0001;
        end
      end else begin
        if (atZero) begin
          nxt_st.dir = DSP_DIR_UP;
          nxt_st.cnt = st_ff.cnt + 16'h0001;
        end else begin
          nxt_st.cnt = st_ff.cnt - 16'h0001;
        end
      end
    end

    // Control and data writes win over counting
    if (busWr && (st_ff.addr == `DSP_OFS_CTRL)) begin
      nxt_st.ctrl.wgm  = hwdata[`DSP_F_WGM +: 4];
      nxt_st.ctrl.comA = hwdata[`DSP_F_COMA +: 2];
      nxt_st.ctrl.comB = hwdata[`DSP_F_COMB +: 2];
      nxt_st.ctrl.cs   = hwdata[`DSP_F_CS +: 3];
      nxt_st.ctrl.dirA = hwdata[`DSP_F_DIRA];
      nxt_st.ctrl.dirB = hwdata[`DSP_F_DIRB];
    end
    if (busWr && (st_ff.addr == `DSP_OFS_CNT)) begin
      nxt_st.cnt = hwdata[15:0];
    end
    // capture acts as TOP at once
    if (busWr && (st_ff.addr == `DSP_OFS_CAP)) begin
      nxt_st.cap = hwdata[15:0];
    end

    // Flags: write one clears, a set in the same cycle wins
    if (busWr && (st_ff.addr == `DSP_OFS_FLAGS)) begin
      nxt_st.flg.ovf    = st_ff.flg.ovf & ~hwdata[`DSP_F_OVF];
      nxt_st.flg.ocf[0] = st_ff.flg.ocf[0] & ~hwdata[`DSP_F_OCFA];
      nxt_st.flg.ocf[1] = st_ff.flg.ocf[1] & ~hwdata[`DSP_F_OCFB];
      nxt_st.flg.capf   = st_ff.flg.capf & ~hwdata[`DSP_F_CAPF];
    end
    if (run && atZero) begin
      nxt_st.flg.ovf = 1'b1;
    end
    if (matchA) begin
      nxt_st.flg.ocf[0] = 1'b1;
    end
    if (matchB) begin
      nxt_st.flg.ocf[1] = 1'b1;
    end
    if (run && atTop && topFromCmpA(st_ff.ctrl.wgm)) begin
      nxt_st.flg.ocf[0] = 1'b1;
    end
    if (run && atTop && topFromCap(st_ff.ctrl.wgm)) begin
      nxt_st.flg.capf = 1'b1;
    end

    nxt_st.pinOe[0]  = st_ff.ctrl.dirA && st_ff.ctrl.comA[1];
    nxt_st.pinOe[1]  = st_ff.ctrl.dirB && st_ff.ctrl.comB[1];
    nxt_st.pinOut[0] = st_ff.ctrl.comA[1] && (levelA ^ st_ff.ctrl.comA[0]);
    nxt_st.pinOut[1] = st_ff.ctrl.comB[1] && (levelB ^ st_ff.ctrl.comB[0]);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= StRst;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hreadyout        = st_ff.ready;
  assign hresp            = st_ff.resp;
  assign hrdata           = st_ff.rdata;
  assign compareOutputA   = st_ff.pinOut[0];
  assign compareOutputAOe = st_ff.pinOe[0];
  assign compareOutputB   = st_ff.pinOut[1];
  assign compareOutputBOe = st_ff.pinOe[1];

endmodule : dsp_pwm_timer

/* verification/dsp_pwm_timer_asserts.sv */
`timescale 1ns/1ps
`include "dsp_cfg.svh"

module dsp_pwm_timer_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        compareOutputA,
  input wire logic        compareOutputAOe,
  input wire logic        compareOutputB,
  input wire logic        compareOutputBOe
);
  logic       take;
  logic [3:0] sinceWr_ff;
  logic       ctrlWr_ff;
  logic [1:0] dirSh_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  assign take = hsel && hready && htrans[1] && hreadyout;

  // Saturating age of the last write, so enable changes can be tied to it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sinceWr_ff <= 4'hF;
    end else if (take && hwrite) begin
      sinceWr_ff <= 4'h0;
    end else if (sinceWr_ff != 4'hF) begin
      sinceWr_ff <= sinceWr_ff + 4'h1;
    end
  end

  // Direction bits as last written, so an enable can be held against them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrlWr_ff <= 1'b0;
      dirSh_ff  <= 2'b00;
    end else begin
      ctrlWr_ff <= take && hwrite && (haddr[7:0] == `DSP_OFS_CTRL);
      if (ctrlWr_ff) begin
        dirSh_ff <= {hwdata[`DSP_F_DIRB], hwdata[`DSP_F_DIRA]};
      end
    end
  end

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("slave answered with an error response");
  wait_state_a: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("transfer did not take exactly one wait state");
  one_wait_a: assert property (!hreadyout |=> hreadyout)
    else $error("ready held low for more than one cycle");
  wait_cause_a: assert property ($fell(hreadyout) |-> $past(take))
    else $error("wait state without an accepted transfer");
  read_load_a: assert property ($changed(hrdata) |-> $past(take && !hwrite, 2))
    else $error("read data changed without a read");
  write_keep_a: assert property (take && hwrite |=> $stable(hrdata) [*2])
    else $error("read data disturbed by a write");

  // ----------------------------------------
  // Pin enables
  // ----------------------------------------
  oe_a_follow_a: assert property ($changed(compareOutputAOe) |-> sinceWr_ff <= 4'h5)
    else $error("pin A enable moved without a register write");
  oe_b_follow_a: assert property ($changed(compareOutputBOe) |-> sinceWr_ff <= 4'h5)
    else $error("pin B enable moved without a register write");
  pin_a_dir_a: assert property (sinceWr_ff > 4'h2 && compareOutputAOe |-> dirSh_ff[0])
    else $error("pin A driven while its direction bit is clear");
  pin_b_dir_a: assert property (sinceWr_ff > 4'h2 && compareOutputBOe |-> dirSh_ff[1])
    else $error("pin B driven while its direction bit is clear");

  rd_seen_c: cover property (take && !hwrite);
  oe_rise_c: cover property ($rose(compareOutputBOe));
  pin_rise_c: cover property ($rose(compareOutputA));
  pin_fall_c: cover property ($fell(compareOutputB));
endmodule : dsp_pwm_timer_chk

/* verification/dsp_pwm_load.sv */
`timescale 1ns/1ps

module dsp_pwm_load (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        pinOut,
  input  wire logic        pinOe,
  output logic             pad_ff,
  output logic [31:0]      hiLen_ff,
  output logic [31:0]      loLen_ff,
  output logic [31:0]      edges_ff
);
  logic        level;
  logic [31:0] run_ff;

  // No pull on the line: an undriven pad flips, so a stale level never passes
  assign level = pinOe ? pinOut : ~pad_ff;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pad_ff   <= 1'h0;
      run_ff   <= 32'h0;
      hiLen_ff <= 32'h0;
      loLen_ff <= 32'h0;
      edges_ff <= 32'h0;
    end else if (level != pad_ff) begin
      if (pad_ff) begin
        hiLen_ff <= run_ff;
      end else begin
        loLen_ff <= run_ff;
      end
      pad_ff   <= level;
      run_ff   <= 32'h1;
      edges_ff <= edges_ff + 32'h1;
    end else begin
      run_ff <= run_ff + 32'h1;
    end
  end
endmodule : dsp_pwm_load

/* verification/tb_top.sv */
`timescale 1ns/1ps
`include "dsp_cfg.svh"

module tb_top;
  logic        clk, nrst, hsel, hwrite, hreadyout, hresp, padA, padB;
  logic        compareOutputA, compareOutputAOe, compareOutputB, compareOutputBOe;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, hiA, loA, edA, hiB, loB, edB;
  int          nErrors, samplesChecked;

  initial begin
    clk = 1'h0; nrst = 1'h0; hsel = 1'h0; hwrite = 1'h0; htrans = 2'h0;
    hsize = 3'h2; haddr = 32'h0; hwdata = 32'h0;
  end
  always #2 clk = ~clk;

  dsp_pwm_timer dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .compareOutputA(compareOutputA), .compareOutputAOe(compareOutputAOe),
    .compareOutputB(compareOutputB), .compareOutputBOe(compareOutputBOe));
  dsp_pwm_load loadA (.clk(clk), .nrst(nrst), .pinOut(compareOutputA), .pinOe(compareOutputAOe),
    .pad_ff(padA), .hiLen_ff(hiA), .loLen_ff(loA), .edges_ff(edA));
  dsp_pwm_load loadB (.clk(clk), .nrst(nrst), .pinOut(compareOutputB), .pinOe(compareOutputBOe),
    .pad_ff(padB), .hiLen_ff(hiB), .loLen_ff(loB), .edges_ff(edB));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nErrors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task wrapUp;
    $display("comparisons %0d, mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrapUp

  // Holds the address phase until ready, then the data phase until ready again
  task busXfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'h1; htrans <= 2'h2; hwrite <= wr; haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask : busXfer

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task testReset;
    busXfer(1'h1, 8'h1C, 32'hFFFF);
    for (int i = 0; i < 8; i++) begin
      busXfer(1'h0, 8'(i * 4), 32'h0);
      check(rd, (8'(i * 4) == `DSP_OFS_STAT) ? 32'h1 : 32'h0);
    end
    $display("reset values done");
  endtask : testReset

  task automatic testMask;
    logic [3:0]  wgm [4] = '{4'h1, 4'h2, 4'h3, 4'hA};
    logic [15:0] msk [4] = '{16'h00FF, 16'h01FF, 16'h03FF, 16'hFFFF};
    for (int i = 0; i < 4; i++) begin
      busXfer(1'h1, `DSP_OFS_CTRL, {28'h0, wgm[i]});
      busXfer(1'h1, `DSP_OFS_CMPA, 32'hFFFF);
      busXfer(1'h1, `DSP_OFS_CMPB, 32'hFFFF);
      busXfer(1'h0, `DSP_OFS_CMPA, 32'h0);
      check(rd, {16'h0, msk[i]});
      busXfer(1'h0, `DSP_OFS_CMPB, 32'h0);
      check(rd, {16'h0, msk[i]});
    end
    $display("compare masking done");
  endtask : testMask

  task automatic testCount;
    logic [15:0] seq [7] = '{16'h1, 16'h2, 16'h3, 16'h2, 16'h1, 16'h0, 16'h1};
    logic [3:0]  wgm [2] = '{4'hA, 4'h8};
    logic [15:0] last;
    int          k;
    for (int m = 0; m < 2; m++) begin
      busXfer(1'h1, `DSP_OFS_CTRL, {28'h0, wgm[m]});
      busXfer(1'h1, `DSP_OFS_CNT, 32'h0);
      busXfer(1'h1, `DSP_OFS_CAP, 32'h3);
      busXfer(1'h1, `DSP_OFS_CMPA, 32'h1);
      busXfer(1'h1, `DSP_OFS_CMPB, 32'h2);
      busXfer(1'h1, `DSP_OFS_FLAGS, 32'hF);
      // Divide by 64 leaves room to catch every counter value between reads
      busXfer(1'h1, `DSP_OFS_CTRL, {28'h0, wgm[m]} | 32'h0300);
      last = 16'h0;
      k = 0;
      while (k < 7) begin
        busXfer(1'h0, `DSP_OFS_CNT, 32'h0);
        if (rd[15:0] !== last) begin
          check(rd, {16'h0, seq[k]});
          last = rd[15:0];
          k++;
        end
      end
      busXfer(1'h1, `DSP_OFS_CTRL, {28'h0, wgm[m]});
      busXfer(1'h0, `DSP_OFS_FLAGS, 32'h0);
      check(rd, 32'hF);
      busXfer(1'h1, `DSP_OFS_FLAGS, 32'hF);
      busXfer(1'h0, `DSP_OFS_FLAGS, 32'h0);
      check(rd, 32'h0);
    end
    $display("count sequence done");
  endtask : testCount

  task testPwm(input logic [3:0] wgm, input logic [2:0] cs, input int n, input logic [1:0] com,
               input logic [15:0] top, input logic [15:0] c, input logic chan);
    logic [31:0] ctl, hiE, loE, e0;
    int          per;
    ctl = {28'h0, wgm} | {21'h0, cs, 8'h00};
    if (chan) ctl = ctl | {24'h0, com, 6'h0} | 32'h1000;
    else ctl = ctl | {26'h0, com, 4'h0} | 32'h0800;
    busXfer(1'h1, `DSP_OFS_CTRL, {28'h0, wgm});
    busXfer(1'h1, `DSP_OFS_CNT, 32'h0);
    // every TOP is at least 3 and no compare exceeds it
    // a new TOP enters while stopped or through the A buffer
    busXfer(1'h1, `DSP_OFS_CAP, {16'h0, top});
    busXfer(1'h1, `DSP_OFS_CMPA, {16'h0, chan ? top : c});
    busXfer(1'h1, `DSP_OFS_CMPB, {16'h0, c});
    busXfer(1'h1, `DSP_OFS_CTRL, ctl);
    per = 2 * top * n;
    // Three periods let buffered compares and a stale TOP settle first
    repeat (3 * per + 40) @(posedge clk);
    e0 = chan ? edB : edA;
    repeat (per) @(posedge clk);
    hiE = 2 * c * n;
    loE = 2 * (top - c) * n;
    if (com == 2'h3) {hiE, loE} = {loE, hiE};
    check({31'h0, chan ? compareOutputBOe : compareOutputAOe}, 32'h1);
    if (c == 16'h0 || c == top) begin
      check((chan ? edB : edA) - e0, 32'h0);
      check({31'h0, chan ? padB : padA}, {31'h0, (c != 16'h0) ^ (com == 2'h3)});
    end else begin
      check(chan ? hiB : hiA, hiE);
      check(chan ? loB : loA, loE);
    end
    $display("pwm mode %h divide %0d done", wgm, n);
  endtask : testPwm

  task testDirOff;
    busXfer(1'h1, `DSP_OFS_CTRL, 32'h01AA);
    repeat (8) @(posedge clk);
    check({31'h0, compareOutputAOe}, 32'h0);
    check({31'h0, compareOutputBOe}, 32'h0);
    // Clock select six has no divider, so the counter must stand
    busXfer(1'h1, `DSP_OFS_CTRL, 32'h060A);
    busXfer(1'h1, `DSP_OFS_CNT, 32'h5);
    repeat (16) @(posedge clk);
    busXfer(1'h0, `DSP_OFS_CNT, 32'h0);
    check(rd, 32'h5);
    $display("direction bits off done");
  endtask : testDirOff

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'h1;
    testReset;
    testMask;
    testCount;
    testPwm(4'hA, 3'h1, 1, 2'h2, 16'h0014, 16'h0005, 1'h0);
    testPwm(4'hA, 3'h2, 8, 2'h3, 16'h000A, 16'h0004, 1'h1);
    testPwm(4'hB, 3'h1, 1, 2'h2, 16'h0009, 16'h0002, 1'h1);
    testPwm(4'h8, 3'h1, 1, 2'h3, 16'h000C, 16'h0003, 1'h0);
    testPwm(4'h9, 3'h4, 256, 2'h2, 16'h0004, 16'h0001, 1'h1);
    testPwm(4'h1, 3'h1, 1, 2'h2, 16'h00FF, 16'h0040, 1'h0);
    testPwm(4'h2, 3'h1, 1, 2'h3, 16'h01FF, 16'h0100, 1'h1);
    testPwm(4'h3, 3'h1, 1, 2'h2, 16'h03FF, 16'h0200, 1'h0);
    testPwm(4'hA, 3'h5, 1024, 2'h2, 16'h0003, 16'h0001, 1'h1);
    testPwm(4'hA, 3'h1, 1, 2'h2, 16'h0008, 16'h0000, 1'h0);
    testPwm(4'hA, 3'h1, 1, 2'h3, 16'h0008, 16'h0008, 1'h1);
    testDirOff;
    wrapUp;
  end

  // Whole run needs about 50000 cycles; 90000 means a hang
  initial begin
    repeat (90000) @(posedge clk);
    nErrors++;
    wrapUp;
  end
endmodule : tb_top

bind dsp_pwm_timer dsp_pwm_timer_chk chk (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .compareOutputA(compareOutputA),
  .compareOutputAOe(compareOutputAOe), .compareOutputB(compareOutputB),
  .compareOutputBOe(compareOutputBOe));
